// >>> rtl/sup_pkg.sv
package sup_pkg;

  // ****************************************
  // buffer and length limits
  // ****************************************
  localparam int PKT_LEN_MAX = 1024;
  localparam int BUF_DEPTH_DFLT = 1024;
  localparam int LEN_W = 11;

  // ****************************************
  // idle flush timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  localparam int IDLE_W = 16;

  // ****************************************
  // udp destinations and listen port
  // ****************************************
  localparam int NUM_RANGES = 4;
  localparam int RANGE_SPAN_MAX = 64;
  localparam logic [7:0] BCAST_OCTET = 8'hFF;
  localparam logic [15:0] LISTEN_PORT_DFLT = 16'h0FA1;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [LEN_W-1:0] COUNT_RST = 11'h000;
  localparam logic [IDLE_W-1:0] IDLE_RST = 16'h0000;
  localparam logic [1:0] EXTRA_RST = 2'h0;

  // ****************************************
  // delimiter handling options and states
  // ****************************************
  typedef enum logic [1:0] {
    DP_NOTHING = 2'h0,
    DP_PLUS1 = 2'h1,
    DP_PLUS2 = 2'h2,
    DP_STRIP = 2'h3
  } sup_delim_proc_t;

  typedef enum logic [1:0] {
    ST_FILL = 2'b01,
    ST_DRAIN = 2'b10
  } sup_state_t;

endpackage : sup_pkg

// >>> rtl/sup_packer.sv
`timescale 1ns/1ns
`default_nettype none
module sup_packer
  import sup_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_DEPTH_DFLT,
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial characters in
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  // packet stream out
  output logic pktValid,
  output logic [7:0] pktData,
  output logic pktLast,
  input wire logic pktReady,
  // packing configuration
  input wire logic [LEN_W-1:0] cfgPktLen,
  input wire logic cfgDelim1En,
  input wire logic [7:0] cfgDelim1,
  input wire logic cfgDelim2En,
  input wire logic [7:0] cfgDelim2,
  input wire logic [1:0] cfgDelimProc,
  input wire logic [IDLE_W-1:0] cfgForceMs,
  // udp destinations
  input wire logic [NUM_RANGES-1:0] destEn,
  input wire logic [NUM_RANGES*32-1:0] destBegin,
  input wire logic [NUM_RANGES*32-1:0] destEnd,
  output logic [NUM_RANGES-1:0] rangeUsable,
  output logic [NUM_RANGES-1:0] rangeBcast,
  output logic destCfgError,
  // incoming udp port check
  input wire logic [15:0] cfgListenPort,
  input wire logic udpPortValid,
  input wire logic [15:0] udpDstPort,
  output logic portMatch
);

  localparam int AW = $clog2(BUF_DEPTH);
  localparam logic [LEN_W-1:0] DEPTH_L = LEN_W'(BUF_DEPTH);
  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

  // ****************************************
  // state
  // ****************************************
  sup_state_t state_r, state_nxt;
  logic [LEN_W-1:0] count_r, count_nxt;
  logic [LEN_W-1:0] rdIdx_r, rdIdx_nxt;
  logic prevD1_r, prevD1_nxt;
  logic [1:0] extra_r, extra_nxt;
  logic [31:0] preCnt_r, preCnt_nxt;
  logic [IDLE_W-1:0] msCnt_r, msCnt_nxt;
  logic rxReady_r, rxReady_nxt;
  logic pktValid_r, pktValid_nxt;
  logic [7:0] pktData_r, pktData_nxt;
  logic pktLast_r, pktLast_nxt;
  logic [7:0] mem [BUF_DEPTH];
  logic wrEn;
  logic accept;
  logic delimHit;
  logic flush;
  logic [LEN_W-1:0] grown;

  assign accept = rxValid & rxReady_r & (state_r == ST_FILL);

  // ****************************************
  // packing decisions and drain sequencing
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    rdIdx_nxt = rdIdx_r;
    prevD1_nxt = prevD1_r;
    extra_nxt = extra_r;
    preCnt_nxt = preCnt_r;
    msCnt_nxt = msCnt_r;
    pktValid_nxt = pktValid_r;
    pktData_nxt = pktData_r;
    pktLast_nxt = pktLast_r;
    wrEn = 1'b0;
    delimHit = 1'b0;
    flush = 1'b0;
    grown = count_r + 11'h001;
    case (state_r)
      ST_FILL: begin
        if (accept) begin
          // any character restarts the idle timer
          preCnt_nxt = 32'h0000_0000;
          msCnt_nxt = IDLE_RST;
          if (extra_r != EXTRA_RST) begin
            // trailing characters after a match
            wrEn = 1'b1;
            count_nxt = grown;
            extra_nxt = extra_r - 2'h1;
            flush = (extra_r == 2'h1);
          end else begin
            if (cfgDelim1En && !cfgDelim2En) begin
              delimHit = (rxData == cfgDelim1);
            end else if (cfgDelim1En) begin
              delimHit = prevD1_r && (rxData == cfgDelim2);
            end
            prevD1_nxt = cfgDelim1En && (rxData == cfgDelim1);
            if (delimHit && cfgDelimProc == DP_STRIP) begin
              // drop this delimiter, and the first one of a pair
              count_nxt = cfgDelim2En ? count_r - 11'h001 : count_r;
              flush = 1'b1;
            end else begin
              wrEn = 1'b1;
              count_nxt = grown;
              if (delimHit && cfgDelimProc == DP_PLUS1) begin
                extra_nxt = 2'h1;
              end else if (delimHit && cfgDelimProc == DP_PLUS2) begin
                extra_nxt = 2'h2;
              end else if (delimHit) begin
                flush = 1'b1;
              end
            end
          end
          // length threshold, only when nonzero
          if (cfgPktLen != COUNT_RST && count_nxt >= cfgPktLen) begin
            flush = 1'b1;
          end
          if (count_nxt == DEPTH_L) begin
            flush = 1'b1;
          end
        end else if (count_r != COUNT_RST) begin
          // millisecond prescaler while data waits
          if (preCnt_r == MS_LAST) begin
            preCnt_nxt = 32'h0000_0000;
            if (msCnt_r != {IDLE_W{1'b1}}) begin
              msCnt_nxt = msCnt_r + 16'h0001;
            end
          end else begin
            preCnt_nxt = preCnt_r + 32'h0000_0001;
          end
          if (cfgForceMs != IDLE_RST && msCnt_r >= cfgForceMs) begin
            flush = 1'b1;
          end
        end
        if (flush) begin
          // at most one packet whatever the number of causes
          prevD1_nxt = 1'b0;
          extra_nxt = EXTRA_RST;
          preCnt_nxt = 32'h0000_0000;
          msCnt_nxt = IDLE_RST;
          rdIdx_nxt = COUNT_RST;
          state_nxt = (count_nxt == COUNT_RST) ? ST_FILL : ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!pktValid_r || pktReady) begin
          if (rdIdx_r < count_r) begin
            pktValid_nxt = 1'b1;
            pktData_nxt = mem[rdIdx_r[AW-1:0]];
            pktLast_nxt = (rdIdx_r == count_r - 11'h001);
            rdIdx_nxt = rdIdx_r + 11'h001;
          end else begin
            // packet done, buffer empties
            pktValid_nxt = 1'b0;
            pktLast_nxt = 1'b0;
            count_nxt = COUNT_RST;
            state_nxt = ST_FILL;
          end
        end
      end
      default: begin
        state_nxt = ST_FILL;
      end
    endcase
    rxReady_nxt = (state_nxt == ST_FILL);
  end

  // registers of the packer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_FILL;
      count_r <= COUNT_RST;
      rdIdx_r <= COUNT_RST;
      prevD1_r <= 1'b0;
      extra_r <= EXTRA_RST;
      preCnt_r <= 32'h0000_0000;
      msCnt_r <= IDLE_RST;
      rxReady_r <= 1'b0;
      pktValid_r <= 1'b0;
      pktData_r <= 8'h00;
      pktLast_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      rdIdx_r <= rdIdx_nxt;
      prevD1_r <= prevD1_nxt;
      extra_r <= extra_nxt;
      preCnt_r <= preCnt_nxt;
      msCnt_r <= msCnt_nxt;
      rxReady_r <= rxReady_nxt;
      pktValid_r <= pktValid_nxt;
      pktData_r <= pktData_nxt;
      pktLast_r <= pktLast_nxt;
    end
  end

  // character buffer, no reset needed
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[count_r[AW-1:0]] <= rxData;
    end
  end

  // ****************************************
  // destination range checks
  // ****************************************
  logic [NUM_RANGES-1:0] usable_nxt, usable_r;
  logic [NUM_RANGES-1:0] bcast_nxt, bcast_r;
  logic cfgErr_r, cfgErr_nxt;
  logic portMatch_r, portMatch_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RANGES; gi++) begin : g_range
      logic [31:0] rb;
      logic [31:0] re;
      logic [31:0] span;
      assign rb = destBegin[gi*32 +: 32];
      assign re = destEnd[gi*32 +: 32];
      assign span = re - rb;
      // broadcast begin covers hosts 1 to 254
      assign bcast_nxt[gi] = destEn[gi] && (rb[7:0] == BCAST_OCTET);
      assign usable_nxt[gi] = destEn[gi] && (bcast_nxt[gi] ||
        (re >= rb && span < 32'(RANGE_SPAN_MAX)));
    end
  endgenerate

  // at least one usable range, listen port match
  always_comb begin
    cfgErr_nxt = (usable_nxt == '0);
    portMatch_nxt = udpPortValid && (udpDstPort == cfgListenPort);
  end

  // registers of the udp side
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      usable_r <= '0;
      bcast_r <= '0;
      cfgErr_r <= 1'b1;
      portMatch_r <= 1'b0;
    end else begin
      usable_r <= usable_nxt;
      bcast_r <= bcast_nxt;
      cfgErr_r <= cfgErr_nxt;
      portMatch_r <= portMatch_nxt;
    end
  end

  // outputs straight from flops
  assign rxReady = rxReady_r;
  assign pktValid = pktValid_r;
  assign pktData = pktData_r;
  assign pktLast = pktLast_r;
  assign rangeUsable = usable_r;
  assign rangeBcast = bcast_r;
  assign destCfgError = cfgErr_r;
  assign portMatch = portMatch_r;

endmodule : sup_packer
`default_nettype wire

// >>> dv/sup_sink.sv
`timescale 1ns/1ns
`default_nettype none
module sup_sink (
  // clock, reset, pacing
  input wire logic core_clk,
  input wire logic rst,
  input wire logic stall,
  // packet stream
  input wire logic pktValid,
  input wire logic [7:0] pktData,
  input wire logic pktLast,
  output logic pktReady
);
  logic [8:0] got[$];
  int pkts = 0;
  initial pktReady = 1'b0;
  // log bytes; ready toggles while stalling
  always @(posedge core_clk) begin
    if (pktValid && pktReady) begin
      got.push_back({pktLast, pktData});
      pkts += int'(pktLast);
    end
    pktReady <= #1 !rst && (!stall || !pktReady); // no inactivity close
  end
endmodule : sup_sink
`default_nettype wire

// >>> dv/sup_packer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sup_packer_sva
  import sup_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // streams
  input wire logic rxReady,
  input wire logic pktValid,
  input wire logic [7:0] pktData,
  input wire logic pktLast,
  input wire logic pktReady,
  // udp side
  input wire logic [NUM_RANGES-1:0] rangeUsable,
  input wire logic [NUM_RANGES-1:0] rangeBcast,
  input wire logic destCfgError,
  input wire logic [15:0] cfgListenPort,
  input wire logic udpPortValid,
  input wire logic [15:0] udpDstPort,
  input wire logic portMatch
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // stream handshakes
  a_drain_blocks: assert property (pktValid |-> !rxReady)
    else $error("ready in drain");
  a_byte_hold: assert property (pktValid && !pktReady |=>
    pktValid && $stable({pktData, pktLast})) else $error("byte moved");
  a_last_valid: assert property (pktLast |-> pktValid) else $error("stray last");
  a_ready_back: assert property ($fell(pktValid) |-> rxReady) else $error("no ready");
  // udp outputs
  a_port_hit: assert property (udpPortValid && udpDstPort == cfgListenPort |=>
    portMatch) else $error("port missed");
  a_port_miss: assert property (!(udpPortValid && udpDstPort == cfgListenPort) |=>
    !portMatch) else $error("false port");
  a_bcast_usable: assert property ((rangeBcast & ~rangeUsable) == 4'h0)
    else $error("bcast unusable");
  a_cfg_error: assert property (destCfgError == ~|rangeUsable)
    else $error("error flag");
endmodule : sup_packer_sva
bind sup_packer sup_packer_sva sup_packer_sva_i (
  .core_clk(core_clk),
  .rst(rst),
  .rxReady(rxReady),
  .pktValid(pktValid),
  .pktData(pktData),
  .pktLast(pktLast),
  .pktReady(pktReady),
  .rangeUsable(rangeUsable),
  .rangeBcast(rangeBcast),
  .destCfgError(destCfgError),
  .cfgListenPort(cfgListenPort),
  .udpPortValid(udpPortValid),
  .udpDstPort(udpDstPort),
  .portMatch(portMatch)
);
`default_nettype wire

// >>> dv/sup_packer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sup_packer_tb
  import sup_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, rxValid = 1'b0, stall = 1'b0, udpPortValid = 1'b0;
  logic cfgDelim1En = 1'b0, cfgDelim2En = 1'b0, rxReady, pktValid, pktLast, pktReady;
  logic destCfgError, portMatch;
  logic [7:0] rxData = 8'h00, cfgDelim1 = 8'h0D, cfgDelim2 = 8'h42, pktData;
  logic [LEN_W-1:0] cfgPktLen = COUNT_RST;
  logic [1:0] cfgDelimProc = 2'h0;
  logic [15:0] cfgForceMs = IDLE_RST, cfgListenPort = LISTEN_PORT_DFLT, udpDstPort = 16'h0000;
  logic [3:0] destEn = 4'h0, rangeUsable, rangeBcast;
  logic [127:0] destBegin = 128'h0, destEnd = 128'h0;
  int fails = 0, checks_done = 0;
  sup_packer #(.BUF_DEPTH(16), .MS_CYCLES(4)) sup_packer_i (
    .core_clk(core_clk),
    .rst(rst),
    .rxValid(rxValid),
    .rxData(rxData),
    .rxReady(rxReady),
    .pktValid(pktValid),
    .pktData(pktData),
    .pktLast(pktLast),
    .pktReady(pktReady),
    .cfgPktLen(cfgPktLen),
    .cfgDelim1En(cfgDelim1En),
    .cfgDelim1(cfgDelim1),
    .cfgDelim2En(cfgDelim2En),
    .cfgDelim2(cfgDelim2),
    .cfgDelimProc(cfgDelimProc),
    .cfgForceMs(cfgForceMs),
    .destEn(destEn),
    .destBegin(destBegin),
    .destEnd(destEnd),
    .rangeUsable(rangeUsable),
    .rangeBcast(rangeBcast),
    .destCfgError(destCfgError),
    .cfgListenPort(cfgListenPort),
    .udpPortValid(udpPortValid),
    .udpDstPort(udpDstPort),
    .portMatch(portMatch)
  );
  sup_sink sup_sink_i (
    .core_clk(core_clk),
    .rst(rst),
    .stall(stall),
    .pktValid(pktValid),
    .pktData(pktData),
    .pktLast(pktLast),
    .pktReady(pktReady)
  );
  // clock
  initial forever #2 core_clk = ~core_clk;
  // compare one value
  task automatic cmp(input logic [8:0] g, x);
    checks_done++;
    if (g !== x) $display("[ERR] %0t got %0h exp %0h", $time, g, x);
    fails += int'(g !== x);
  endtask : cmp
  // offer a character until taken
  task automatic send(input logic [7:0] d);
    rxValid = 1'b1;
    rxData = d;
    @(posedge core_clk);
    for (int n = 0; rxReady !== 1'b1 && n < 500; n++) @(posedge core_clk);
    if (rxReady !== 1'b1) begin
      $display("[ERR] %0t got %0h exp %0h", $time, rxReady, 1'b1);
      fails++;
    end
    #1;
  endtask : send
  // wait for packets, compare the log
  task automatic expk(input int np, input logic [8:0] e[$]);
    rxValid = 1'b0;
    for (int n = 0; sup_sink_i.pkts < np && n < 3000; n++) @(posedge core_clk);
    repeat (20) @(posedge core_clk);
    #1 cmp(9'(sup_sink_i.pkts), 9'(np));
    cmp(9'(sup_sink_i.got.size()), 9'(e.size()));
    foreach (e[i]) cmp(sup_sink_i.got[i], e[i]);
    sup_sink_i.got.delete();
    sup_sink_i.pkts = 0;
  endtask : expk
  // length or full flush, slow sink
  task automatic t_len(input int len, n, sz);
    logic [8:0] e[$];
    cfgPktLen = 11'(len);
    stall = 1'b1;
    for (int i = 1; i <= n; i++) begin
      send(8'(i));
      e.push_back({i % sz == 0, 8'(i)});
    end
    expk(n / sz, e);
    stall = 1'b0;
    $display("length %0d done", len);
  endtask : t_len
  // every delimiter option, then pair and disabled
  task automatic t_delim();
    logic [7:0] s[4] = '{8'h41, 8'h0D, 8'h42, 8'h43};
    int cut[6] = '{1, 2, 3, 0, 3, 0};
    logic [8:0] e[$];
    cfgForceMs = 16'h0002;
    cfgPktLen = 11'h000;
    for (int p = 0; p < 6; p++) begin
      e.delete();
      cfgDelim1En = p != 4;
      cfgDelim2En = p == 5;
      cfgDelimProc = 2'(p > 3 ? 3 : p);
      foreach (s[i]) begin
        send(s[i]);
        if (!(p == 3 && i == 1 || p == 5 && i inside {1, 2}))
          e.push_back({i == cut[p] || i == 3, s[i]});
      end
      expk(cut[p] == 3 ? 1 : 2, e);
    end
    cfgDelim1En = 1'b0;
    cfgDelim2En = 1'b0;
    $display("delimiter done");
  endtask : t_delim
  // idle flush off, on, and restarted
  task automatic t_idle();
    cfgForceMs = 16'h0000;
    cfgPktLen = 11'h002;
    send(8'h51);
    rxValid = 1'b0;
    repeat (100) @(posedge core_clk);
    #1 send(8'h52);
    expk(1, '{9'h051, 9'h152});
    cfgPktLen = 11'h000;
    cfgForceMs = 16'h0003;
    send(8'h53);
    rxValid = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 send(8'h54);
    rxValid = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 cmp(9'(sup_sink_i.pkts), 9'h000);
    expk(1, '{9'h053, 9'h154});
    $display("idle done");
  endtask : t_idle
  // destination ranges and listen port
  task automatic t_udp();
    cmp(9'(destCfgError), 9'h001);
    destEn = 4'h7;
    destBegin = {32'h0, 32'hC0A801FF, 32'h0A000001, 32'h0A000001};
    destEnd = {64'h0, 32'h0A000041, 32'h0A000040};
    udpPortValid = 1'b1;
    udpDstPort = LISTEN_PORT_DFLT;
    @(posedge core_clk);
    #1 udpPortValid = 1'b0;
    cmp(9'(portMatch), 9'h001);
    cmp(9'(rangeUsable), 9'h005);
    cmp(9'(rangeBcast), 9'h004);
    cmp(9'(destCfgError), 9'h000);
    udpPortValid = 1'b1;
    udpDstPort = LISTEN_PORT_DFLT + 16'h0001;
    @(posedge core_clk);
    #1 udpPortValid = 1'b0;
    cmp(9'(portMatch), 9'h000);
    $display("udp done");
  endtask : t_udp
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    @(posedge core_clk);
    #1 t_len(3, 6, 3);
    t_len(0, 16, 16);
    t_len(16, 16, 16);
    t_delim();
    t_idle();
    t_udp();
    give_verdict();
  end
  // watchdog
  initial begin
    #100000 fails++;
    give_verdict();
  end
endmodule : sup_packer_tb
`default_nettype wire
